// ==== include/asd_consts.vh ====
// constants of the serial output formatting and shutdown block
// assumes inclusion by bare name from the design files
`ifndef ASD_CONSTS_VH
`define ASD_CONSTS_VH

// input word: seven bits after the start bit, first received lands in bit 6
`define ASD_WORD_LAST 3'h6
`define ASD_POS_CFG_SEL 6
`define ASD_POS_ODD_SIGN 5
`define ASD_POS_SEL_HI 4
`define ASD_POS_SEL_LO 3
`define ASD_POS_POLARITY 2
`define ASD_POS_BIT_ORDER 1
`define ASD_POS_SHUTDOWN_N 0

// result coding
`define ASD_RESULT_MSB 11

// output stream steps counted in serial clock falls
`define ASD_STEP_NULL 5'h00
`define ASD_STEP_MSB_END 5'h0C
`define ASD_STEP_LSB_END 5'h17
`define ASD_STEP_MAX 5'h1F

// reset values
`define ASD_RST_WORD 7'h00
`define ASD_RST_RESULT 12'h000
`define ASD_RST_STEP 5'h00
`define ASD_RST_PINS 3'h1

`endif

// ==== verilog/asd_sync.v ====
// two flip-flop synchroniser for the three link pins
// assumes pins are asynchronous to clk; reset value given per bit
`timescale 1ns/100ps
`default_nettype none
module asd_sync (
   input wire clk,
   input wire sys_rst,
   input wire [2:0] rstVal,
   input wire [2:0] pinIn,
   output wire [2:0] pinSync
);
   genvar i;
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_bit
         reg stage1_q;
         reg stage2_q;
         // reset value is a fixed constant at the instance, so still a constant load
         always @(posedge clk) begin
            if (sys_rst) begin
               stage1_q <= rstVal[i];
               stage2_q <= rstVal[i];
            end else begin
               stage1_q <= pinIn[i];
               stage2_q <= stage1_q;
            end
         end
         assign pinSync[i] = stage2_q;
      end
   endgenerate
endmodule // asd_sync
`default_nettype wire

// ==== verilog/asd_bit_pick.v ====
// selects the serial output bit for a given step of the output stream
// assumes step 0 is the null bit and the caller registers the result
`timescale 1ns/100ps
`default_nettype none
`include "asd_consts.vh"
module asd_bit_pick (
   input wire [4:0] step,
   input wire [11:0] result,
   input wire msbFirstOnly,
   input wire bipolar,
   input wire shutdown,
   output reg bitOut
);
   wire [4:0] idxDown;
   wire [4:0] idxUp;
   assign idxDown = `ASD_STEP_MSB_END - step;
   assign idxUp = step - `ASD_STEP_MSB_END;
   always @* begin
      bitOut = 1'b0;
      if (step == `ASD_STEP_NULL) begin
         bitOut = 1'b0;
      end else if (step <= `ASD_STEP_MSB_END) begin
         if (shutdown) begin
            bitOut = 1'b1;
         end else begin
            bitOut = result[idxDown[3:0]];
         end
      end else if (shutdown) begin
         bitOut = 1'b0;
      end else if (msbFirstOnly) begin
         bitOut = 1'b0;
      end else if (step <= `ASD_STEP_LSB_END) begin
         bitOut = result[idxUp[3:0]];
      end else begin
         // sign repeats only for bipolar; unipolar fills zeros
         bitOut = bipolar & result[`ASD_RESULT_MSB];
      end
   end
endmodule // asd_bit_pick
`default_nettype wire

// ==== verilog/asd_serial_core.v ====
// serial interface, result coding and power shutdown of the converter
// assumes sampleCode is offset binary from the converter core on clk
// Operation
// - unipolar result is straight binary
// - bipolar result is two's complement
// - order bit one shifts MSB first
// - MSB-first-only fills zeros after last bit
// - order bit zero: MSB first, then LSB first
// - bipolar MSB/LSB mode fills with sign
// - shutdown bit zero enters power shutdown
// - shutdown answer: twelve ones then zeros
// - output high impedance after select rises
// - shutdown ends at next select cycle
// - no wait after shutdown; accept immediately
// - system shutdown output low in shutdown
// - shutdown output low until next select
// - first one after select falls starts
// - one null bit precedes the result
// - select rise resets the serial interface
// - polarity bit one unipolar, zero bipolar
`timescale 1ns/100ps
`default_nettype none
`include "asd_consts.vh"
module asd_serial_core (
   input wire clk,
   input wire sys_rst,
   input wire csPinN,
   input wire sclkPin,
   input wire dinPin,
   input wire [11:0] sampleCode,
   output wire doutPinO,
   output wire doutPinOe,
   output wire systemShutdownOutN,
   output wire powerDown,
   output wire convStart,
   output wire inputConfigSelect,
   output wire muxOddSign,
   output wire [1:0] muxSelect,
   output wire polaritySelect,
   output wire bitOrderSelect
);
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_HUNT = 2'b01;
   localparam [1:0] ST_WORD = 2'b10;
   localparam [1:0] ST_OUT = 2'b11;

   wire [2:0] pinSync;
   wire csSyncN;
   wire sclkSync;
   wire dinSync;
   reg csPrev_q;
   reg sclkPrev_q;
   wire csFall;
   wire sclkRise;
   wire sclkFall;
   reg [1:0] state_q;
   reg [2:0] bitCnt_q;
   reg [6:0] word_q;
   wire [6:0] wordNext;
   reg [4:0] step_q;
   reg dout_q;
   reg doutOe_q;
   reg shutdown_q;
   reg convStart_q;
   reg [11:0] result_q;
   reg cfgSel_q;
   reg oddSign_q;
   reg [1:0] muxSel_q;
   reg polarity_q;
   reg bitOrder_q;
   wire pickedBit;
   wire [11:0] codedResult;
   wire startSeen;
   wire wordDone;
   wire shutdownReq;
   reg [1:0] state_d;
   reg [2:0] bitCnt_d;
   reg [6:0] word_d;
   reg [4:0] step_d;
   reg dout_d;
   reg doutOe_d;
   reg shutdown_d;
   reg convStart_d;
   reg [11:0] result_d;
   reg cfgSel_d;
   reg oddSign_d;
   reg [1:0] muxSel_d;
   reg polarity_d;
   reg bitOrder_d;

   // pins reset to select high, clock low, data low
   asd_sync u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .rstVal(`ASD_RST_PINS),
      .pinIn({dinPin, sclkPin, csPinN}),
      .pinSync(pinSync)
   );
   assign csSyncN = pinSync[0];
   assign sclkSync = pinSync[1];
   assign dinSync = pinSync[2];

   // edges found on the synchronised copies only
   assign csFall = csPrev_q & ~csSyncN;
   assign sclkRise = ~sclkPrev_q & sclkSync;
   assign sclkFall = sclkPrev_q & ~sclkSync;

   assign wordNext = {word_q[5:0], dinSync};

   // offset binary from the core becomes straight binary or two's complement
   assign codedResult = wordNext[`ASD_POS_POLARITY] ? sampleCode
                                                    : {~sampleCode[11], sampleCode[10:0]};

   asd_bit_pick u_pick (
      .step(step_q),
      .result(result_q),
      .msbFirstOnly(bitOrder_q),
      .bipolar(~polarity_q),
      .shutdown(shutdown_q),
      .bitOut(pickedBit)
   );

   always @(posedge clk) begin
      if (sys_rst) begin
         csPrev_q <= 1'b1;
         sclkPrev_q <= 1'b0;
      end else begin
         csPrev_q <= csSyncN;
         sclkPrev_q <= sclkSync;
      end
   end

   assign startSeen = sclkRise & dinSync;
   assign wordDone = ~csSyncN & (state_q == ST_WORD) & sclkRise & (bitCnt_q == `ASD_WORD_LAST);
   assign shutdownReq = ~wordNext[`ASD_POS_SHUTDOWN_N];

   // frame sequencer: select high overrides every state
   always @* begin
      state_d = state_q;
      bitCnt_d = bitCnt_q;
      word_d = word_q;
      step_d = step_q;
      dout_d = dout_q;
      doutOe_d = doutOe_q;
      if (csSyncN) begin
         state_d = ST_IDLE;
         doutOe_d = 1'b0;
         dout_d = 1'b0;
         step_d = `ASD_RST_STEP;
         bitCnt_d = 3'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // no warm-up: hunting starts at once even out of shutdown
               state_d = ST_HUNT;
            end
            ST_HUNT: begin
               if (startSeen) begin
                  state_d = ST_WORD;
                  bitCnt_d = 3'h0;
               end
            end
            ST_WORD: begin
               if (sclkRise) begin
                  word_d = wordNext;
                  bitCnt_d = bitCnt_q + 3'h1;
                  if (bitCnt_q == `ASD_WORD_LAST) begin
                     state_d = ST_OUT;
                     step_d = `ASD_RST_STEP;
                  end
               end
            end
            ST_OUT: begin
               // data changes on the falling serial clock, stable for the next rise
               if (sclkFall) begin
                  dout_d = pickedBit;
                  doutOe_d = 1'b1;
                  // saturating step keeps the fill going for as long as clocks come
                  if (step_q != `ASD_STEP_MAX) begin
                     step_d = step_q + 5'h01;
                  end
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   // word capture; a shutdown set at word end outranks the clear on select fall
   always @* begin
      cfgSel_d = cfgSel_q;
      oddSign_d = oddSign_q;
      muxSel_d = muxSel_q;
      polarity_d = polarity_q;
      bitOrder_d = bitOrder_q;
      result_d = result_q;
      shutdown_d = shutdown_q;
      convStart_d = 1'b0;
      if (csFall) begin
         shutdown_d = 1'b0;
      end
      if (wordDone) begin
         cfgSel_d = wordNext[`ASD_POS_CFG_SEL];
         oddSign_d = wordNext[`ASD_POS_ODD_SIGN];
         muxSel_d = wordNext[`ASD_POS_SEL_HI:`ASD_POS_SEL_LO];
         polarity_d = wordNext[`ASD_POS_POLARITY];
         bitOrder_d = wordNext[`ASD_POS_BIT_ORDER];
         result_d = codedResult;
         if (shutdownReq) begin
            shutdown_d = 1'b1;
         end else begin
            convStart_d = 1'b1;
         end
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         bitCnt_q <= 3'h0;
      end else begin
         state_q <= state_d;
         bitCnt_q <= bitCnt_d;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         word_q <= `ASD_RST_WORD;
      end else begin
         word_q <= word_d;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         step_q <= `ASD_RST_STEP;
      end else begin
         step_q <= step_d;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         dout_q <= 1'b0;
         doutOe_q <= 1'b0;
      end else begin
         dout_q <= dout_d;
         doutOe_q <= doutOe_d;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         shutdown_q <= 1'b0;
      end else begin
         shutdown_q <= shutdown_d;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         convStart_q <= 1'b0;
      end else begin
         convStart_q <= convStart_d;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         result_q <= `ASD_RST_RESULT;
      end else begin
         result_q <= result_d;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         cfgSel_q <= 1'b0;
         oddSign_q <= 1'b0;
         muxSel_q <= 2'h0;
         polarity_q <= 1'b0;
         bitOrder_q <= 1'b0;
      end else begin
         cfgSel_q <= cfgSel_d;
         oddSign_q <= oddSign_d;
         muxSel_q <= muxSel_d;
         polarity_q <= polarity_d;
         bitOrder_q <= bitOrder_d;
      end
   end

   // select high forces release at once, not waiting on the register
   assign doutPinO = dout_q;
   assign doutPinOe = doutOe_q & ~csSyncN;
   assign systemShutdownOutN = ~shutdown_q;
   assign powerDown = shutdown_q;
   assign convStart = convStart_q;
   assign inputConfigSelect = cfgSel_q;
   assign muxOddSign = oddSign_q;
   assign muxSelect = muxSel_q;
   assign polaritySelect = polarity_q;
   assign bitOrderSelect = bitOrder_q;
endmodule // asd_serial_core
`default_nettype wire

// ==== tb/asd_serial_core_assertions.sv ====
// pin-level checker of the serial core
// assumes it is bound to asd_serial_core
`timescale 1ns/100ps
`default_nettype none
module asd_serial_core_assertions (
   input wire clk,
   input wire sys_rst,
   input wire csPinN,
   input wire doutPinO,
   input wire doutPinOe,
   input wire systemShutdownOutN,
   input wire powerDown,
   input wire convStart
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // select lags 2-3 clk through the synchroniser, so five idle samples are safe
   sequence selIdle;
      csPinN [*5];
   endsequence
   sequence selHeld;
      csPinN && $past(csPinN);
   endsequence
   shdn_pair_a: assert property (systemShutdownOutN != powerDown)
      else $error("shutdown pins disagree");
   oe_idle_a: assert property (selIdle |-> !doutPinOe)
      else $error("dout driven while idle");
   oe_drop_a: assert property ($rose(csPinN) |-> ##[1:4] !doutPinOe)
      else $error("dout not released");
   pd_enter_a: assert property ($rose(powerDown) |-> !csPinN && !convStart)
      else $error("shutdown outside exchange");
   pd_hold_a: assert property ((powerDown and selHeld) |=> powerDown)
      else $error("shutdown left early");
   pd_leave_a: assert property ($fell(powerDown) && !$past(sys_rst) |-> !csPinN)
      else $error("shutdown left without select");
   conv_quiet_a: assert property (convStart |-> !powerDown ##1 !convStart)
      else $error("bad conversion pulse");
   null_first_a: assert property ($rose(doutPinOe) |-> ##[0:1] !doutPinO)
      else $error("null bit missing");
endmodule // asd_serial_core_assertions
bind asd_serial_core asd_serial_core_assertions i_asd_serial_core_assertions (.clk, .sys_rst, .csPinN,
   .doutPinO, .doutPinOe, .systemShutdownOutN, .powerDown, .convStart);
`default_nettype wire

// ==== tb/asd_host_model.sv ====
// host end of the link: select, serial clock and data in
// assumes dout settles well inside half a link period
`timescale 1ns/100ps
`default_nettype none
module asd_host_model (
   output logic csPinN,
   output logic sclkPin,
   output logic dinPin,
   input wire doutPinO
);
   // link clock stands low between frames
   initial begin
      csPinN = 1'b1;
      sclkPin = 1'b0;
      dinPin = 1'b0;
   end
   task automatic xfer(input [6:0] w, input int nz, output logic [35:0] cap);
      logic [7:0] sh;
      sh = {1'b1, w};
      csPinN = 1'b0;
      for (int i = 0; i < nz + 8; i++) begin
         dinPin = (i < nz) ? 1'b0 : sh[nz + 7 - i];
         #62.5 sclkPin = 1'b1;
         #62.5 sclkPin = 1'b0;
      end
      for (int i = 0; i < 36; i++) begin
         // released data line toggles, the core must ignore it
         dinPin = ~dinPin;
         #62.5 cap = {cap[34:0], doutPinO};
         sclkPin = 1'b1;
         #62.5 sclkPin = 1'b0;
      end
      csPinN = 1'b1;
      #250;
   endtask
endmodule // asd_host_model
`default_nettype wire

// ==== tb/test_asd_serial_core.sv ====
// self-checking bench: stream model against the serial core
// assumes the host model owns the link pins
`timescale 1ns/100ps
`default_nettype none
module test_asd_serial_core;
   logic clk;
   logic sys_rst;
   logic [11:0] sampleCode;
   logic [15:0] rnd = 16'h004C;
   logic [35:0] cap;
   wire csPinN, sclkPin, dinPin, doutPinO, doutPinOe, systemShutdownOutN, powerDown, convStart;
   wire inputConfigSelect, muxOddSign, polaritySelect, bitOrderSelect;
   wire [1:0] muxSelect;
   // the host sees the inverse while dout is released, so a late enable shows up in the capture
   wire doutLine;
   assign doutLine = doutPinOe ? doutPinO : ~doutPinO;
   int errorCnt = 0;
   int samplesChecked = 0;
   int cyc = 0;
   int convs = 0;
   asd_serial_core i_asd_serial_core (.clk, .sys_rst, .csPinN, .sclkPin, .dinPin, .sampleCode, .doutPinO,
      .doutPinOe, .systemShutdownOutN, .powerDown, .convStart, .inputConfigSelect, .muxOddSign, .muxSelect,
      .polaritySelect, .bitOrderSelect);
   asd_host_model i_asd_host_model (.csPinN, .sclkPin, .dinPin, .doutPinO(doutLine));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic [15:0] nx(input [15:0] s);
      nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // bit 35 is the null bit, then one bit per link clock fall
   function automatic [35:0] expStream(input [6:0] w, input [11:0] c);
      logic [11:0] r;
      r = w[2] ? c : c ^ 12'h800;
      expStream = 36'h0;
      for (int i = 1; i < 36; i++)
         if (!w[0])
            expStream[35 - i] = (i < 13);
         else if (i < 13)
            expStream[35 - i] = r[12 - i];
         else if (!w[1])
            expStream[35 - i] = (i < 24) ? r[i - 12] : !w[2] & r[11];
   endfunction
   task automatic chk(input [63:0] got, input [63:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errorCnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic testDone;
      $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic run(input [6:0] w, input [11:0] c, input int nz);
      int c0;
      @(posedge clk);
      #1;
      sampleCode = c;
      c0 = convs;
      i_asd_host_model.xfer(w, nz, cap);
      chk(cap, expStream(w, c));
      chk({inputConfigSelect, muxOddSign, muxSelect, polaritySelect, bitOrderSelect}, w[6:1]);
      chk(convs - c0, w[0]);
      chk({doutPinOe, powerDown, systemShutdownOutN}, {1'b0, !w[0], w[0]});
   endtask
   always @(posedge clk) begin
      cyc++;
      if (convStart === 1'b1)
         convs++;
      if (cyc == 20000) begin
         errorCnt++;
         testDone;
      end
   end
   initial begin
      sys_rst = 1'b1;
      sampleCode = 12'h000;
      repeat (8) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      chk({doutPinOe, powerDown, systemShutdownOutN, convStart}, 4'h2);
      // 4 and 5 shut down back to back, 6 converts at once after
      for (int k = 0; k < 10; k++) begin
         rnd = nx(rnd);
         run({rnd[15:12], k[1], k[0], k != 4 && k != 5}, k < 2 ? 12'h001 : k < 3 ? 12'hFFF : rnd[11:0], k % 3);
         $display("test %0d done", k);
      end
      testDone;
   end
endmodule // test_asd_serial_core
`default_nettype wire
